// >>> core/sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync2 (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_r;  // first stage, read only by the second
  // two stages in series, cleared by reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// >>> core/timer_gate.sv
// gated 16-bit timer with gate modes, flags and capture/compare base
`timescale 1ns/1ps
module timer_gate
  import tmr_gate_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              count_tick,
  input  wire logic              counter_on,
  input  wire logic              gate_function_enable,
  input  wire logic [1:0]        gate_source_select,
  input  wire logic              gate_polarity,
  input  wire logic              toggle_mode_enable,
  input  wire logic              single_pulse_enable,
  input  wire logic              pulse_arm_set,
  input  wire logic              cmp1_sync_enable,
  input  wire logic              cmp2_sync_enable,
  input  wire logic              external_gate_pin,
  input  wire logic [BYTE_W-1:0] eight_bit_timer,
  input  wire logic              comparator1_out,
  input  wire logic              comparator2_out,
  input  wire logic              overflow_irq_enable,
  input  wire logic              gate_event_irq_enable,
  input  wire logic              peripheral_irq_enable,
  input  wire logic              global_irq_enable,
  input  wire logic              overflow_flag_clear,
  input  wire logic              gate_event_flag_clear,
  input  wire logic              sleep_mode,
  input  wire logic              sync_disable,
  input  wire logic              secondary_osc_select,
  input  wire logic              count_low_we,
  input  wire logic              count_high_we,
  input  wire logic [BYTE_W-1:0] count_wdata,
  input  wire logic              capture_mode,
  input  wire logic              capture_event,
  input  wire logic              auto_conv_trigger,
  output logic [CNT_W-1:0]       count_value,
  output logic [CNT_W-1:0]       capture_compare_pair,
  output logic                   compare_event,
  output logic                   pulse_arm_status,
  output logic                   gate_level_status,
  output logic                   overflow_flag,
  output logic                   gate_event_flag,
  output logic                   overflow_irq,
  output logic                   gate_event_irq,
  output logic                   wake_request,
  output logic                   secondary_osc_run
);
  // synchronised pin-side inputs
  localparam int  N_ASYNC = 3;  // gate pin and two comparators
  logic [2:0]     async_in;     // raw asynchronous inputs
  logic [2:0]     async_s;      // the same after two stages
  logic           pin_s;        // gate pin after two stages
  logic           cmp1_s;       // comparator 1 after two stages
  logic           cmp2_s;       // comparator 2 after two stages
  logic [7:0]     t8_d_r;       // previous 8-bit timer value, same domain
  logic           cmp1_r;       // comparator 1 resampled on count tick
  logic           cmp2_r;       // comparator 2 resampled on count tick
  logic           t8_pulse;     // one-cycle wrap pulse
  logic           gate_sel;     // selected raw gate
  logic           gate_pol;     // polarity corrected gate
  logic           gate_pol_d_r; // previous polarity corrected gate
  logic           gate_rise;    // incrementing edge of the gate
  logic           toggle_r;     // toggle flip-flop
  logic           toggle_nxt;   // toggle next value
  logic           tgl_gate;     // gate after toggle stage
  logic           tgl_gate_d_r; // previous toggle-stage gate
  logic           sp_rise;      // rising edge at the pulse stage input
  logic           sp_fall;      // trailing edge at the pulse stage input
  logic           sp_active_r;  // single pulse window open
  logic           arm_r;        // arm/status bit
  logic           arm_nxt;      // arm next value
  logic           gate_ctl;     // final gate control level
  logic           gval_r;       // latched gate level
  logic           gval_fall;    // falling edge of latched level
  logic           count_en;     // counter advances this cycle
  logic           sleep_ok;     // counting allowed in current power state
  logic           wrap;         // counter wraps this cycle
  logic [15:0]    cnt_r;        // the 16-bit counter
  logic [15:0]    cnt_nxt;      // counter next value
  logic [15:0]    ccp_r;        // capture/compare pair
  logic           ovf_r;        // overflow flag
  logic           gif_r;        // gate event flag

  // pin and comparators each pass two stages before any logic reads them
  assign async_in = {comparator2_out, comparator1_out, external_gate_pin};
  for (genvar g = 0; g < N_ASYNC; g++) begin : sync_gen
    sync2 sync2_i (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (async_in[g]),
      .q       (async_s[g])
    );
  end
  assign pin_s  = async_s[0];
  assign cmp1_s = async_s[1];
  assign cmp2_s = async_s[2];

  // wrap detector on the 8-bit timer value
  always_ff @(posedge sys_clk) begin
    if (rst) t8_d_r <= T8_ZERO;
    else t8_d_r <= eight_bit_timer;
  end
  assign t8_pulse = (t8_d_r == T8_MAX) && (eight_bit_timer == T8_ZERO);

  // comparator outputs optionally resampled on the timer tick
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmp1_r <= 1'b0;
      cmp2_r <= 1'b0;
    end else if (count_tick) begin
      cmp1_r <= cmp1_s;
      cmp2_r <= cmp2_s;
    end
  end

  // source mux and polarity
  assign gate_sel = (gate_source_select == SRC_PIN)    ? pin_s :
                    (gate_source_select == SRC_T8_OVF) ? t8_pulse :
                    (gate_source_select == SRC_CMP1)   ?
                      (cmp1_sync_enable ? cmp1_r : cmp1_s) :
                      (cmp2_sync_enable ? cmp2_r : cmp2_s);
  assign gate_pol = gate_sel ~^ gate_polarity;

  // edge history of gate stages
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gate_pol_d_r <= 1'b0;
      tgl_gate_d_r <= 1'b0;
    end else begin
      gate_pol_d_r <= gate_pol;
      tgl_gate_d_r <= tgl_gate;
    end
  end
  assign gate_rise = gate_pol && !gate_pol_d_r;

  // toggle stage: flips on incrementing edges, cleared when off
  assign toggle_nxt = (!toggle_mode_enable || !counter_on) ? 1'b0 :
                      (gate_rise ? !toggle_r : toggle_r);
  always_ff @(posedge sys_clk) begin
    if (rst) toggle_r <= 1'b0;
    else toggle_r <= toggle_nxt;
  end
  assign tgl_gate = toggle_mode_enable ? toggle_r : gate_pol;

  // single pulse stage
  assign sp_rise = tgl_gate && !tgl_gate_d_r;
  assign sp_fall = !tgl_gate && tgl_gate_d_r;
  assign arm_nxt = !single_pulse_enable ? 1'b0 :
                   pulse_arm_set ? 1'b1 :
                   (sp_active_r && sp_fall) ? 1'b0 : arm_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arm_r       <= 1'b0;
      sp_active_r <= 1'b0;
    end else begin
      arm_r <= arm_nxt;
      // window opens on the edge after arming, closes on trailing edge
      if (!single_pulse_enable || !counter_on) sp_active_r <= 1'b0;
      else if (arm_r && sp_rise && !sp_active_r) sp_active_r <= 1'b1;
      else if (sp_fall) sp_active_r <= 1'b0;
    end
  end
  assign gate_ctl = single_pulse_enable ? (sp_active_r && tgl_gate) :
                    tgl_gate;

  // latched gate level and its falling edge
  always_ff @(posedge sys_clk) begin
    if (rst) gval_r <= 1'b0;
    else gval_r <= gate_ctl;
  end
  assign gval_fall = gval_r && !gate_ctl;

  // counting: sleep allows only the asynchronous external path
  assign sleep_ok = !sleep_mode || sync_disable;
  assign count_en = counter_on && count_tick && sleep_ok &&
                    (!gate_function_enable || gval_r);
  assign wrap     = count_en && (cnt_r == CNT_MAX);

  // counter next value: byte writes beat the auto trigger clear
  always_comb begin
    cnt_nxt = cnt_r;
    if (count_en) cnt_nxt = cnt_r + 16'h0001;
    if (auto_conv_trigger) cnt_nxt = CNT_RESET;
    if (count_low_we) cnt_nxt[BYTE_W-1:0] = count_wdata;
    if (count_high_we) cnt_nxt[CNT_W-1:BYTE_W] = count_wdata;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) cnt_r <= CNT_RESET;
    else cnt_r <= cnt_nxt;
  end

  // capture register
  always_ff @(posedge sys_clk) begin
    if (rst) ccp_r <= CNT_RESET;
    else if (capture_mode && capture_event) ccp_r <= cnt_r;
  end
  assign compare_event = !capture_mode && (ccp_r == cnt_r);

  // sticky flags, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovf_r <= 1'b0;
      gif_r <= 1'b0;
    end else begin
      ovf_r <= (wrap && !auto_conv_trigger && !count_low_we &&
                !count_high_we) || (ovf_r && !overflow_flag_clear);
      gif_r <= gval_fall || (gif_r && !gate_event_flag_clear);
    end
  end

  assign count_value          = cnt_r;
  assign capture_compare_pair = ccp_r;
  assign pulse_arm_status     = arm_r;
  assign gate_level_status    = gval_r;
  assign overflow_flag        = ovf_r;
  assign gate_event_flag      = gif_r;
  assign overflow_irq   = ovf_r && counter_on && overflow_irq_enable &&
                          peripheral_irq_enable && global_irq_enable;
  // gate event request follows its own enable only
  assign gate_event_irq = gif_r && gate_event_irq_enable;
  assign wake_request   = sleep_mode && ovf_r && counter_on &&
                          overflow_irq_enable && peripheral_irq_enable;
  assign secondary_osc_run = secondary_osc_select;

  // checks
  ovf_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
    ovf_r && !overflow_flag_clear |=> ovf_r)
    else $error("overflow flag dropped without clear");
  ovf_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    wrap && !auto_conv_trigger && !count_low_we && !count_high_we
    |=> ovf_r && cnt_r == CNT_RESET)
    else $error("wrap did not set overflow");
  auto_clr_a: assert property (@(posedge sys_clk) disable iff (rst)
    auto_conv_trigger && !count_low_we && !count_high_we
    |=> cnt_r == CNT_RESET && !$rose(ovf_r))
    else $error("auto trigger did not clear counter");
  wr_prio_a: assert property (@(posedge sys_clk) disable iff (rst)
    count_low_we |=> cnt_r[7:0] == $past(count_wdata))
    else $error("byte write lost");
  tgl_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    !toggle_mode_enable |=> !toggle_r)
    else $error("toggle flip-flop not cleared");
  off_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !counter_on && !auto_conv_trigger && !count_low_we && !count_high_we
    |=> $stable(cnt_r))
    else $error("counter moved while off");
  gif_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    gval_fall |=> gif_r)
    else $error("gate fall did not set flag");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    overflow_irq |-> counter_on && global_irq_enable && ovf_r)
    else $error("overflow request without enables");
  arm_done_a: assert property (@(posedge sys_clk) disable iff (rst)
    sp_active_r && sp_fall && single_pulse_enable && !pulse_arm_set
    |=> !arm_r)
    else $error("arm bit not cleared at trailing edge");
  hi_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    count_high_we |=> cnt_r[CNT_W-1:BYTE_W] == $past(count_wdata))
    else $error("high byte write lost");
  done_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    single_pulse_enable && !sp_active_r |=> !gval_r)
    else $error("gate passed outside the pulse window");
  tgl_flip_a: assert property (@(posedge sys_clk) disable iff (rst)
    toggle_mode_enable && counter_on && gate_rise
    |=> toggle_r != $past(toggle_r))
    else $error("toggle flip-flop missed an edge");
  sleep_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    sleep_mode && !sync_disable && !auto_conv_trigger && !count_low_we &&
    !count_high_we |=> $stable(cnt_r))
    else $error("counter moved in synchronous sleep");
  cap_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
    capture_mode && capture_event |=> ccp_r == $past(cnt_r))
    else $error("capture did not copy the counter");
endmodule

// >>> dv/gate_far_side.sv
// far side model: gate pin, comparators and a free-running 8-bit timer
`timescale 1ns/1ps
module gate_far_side
  import tmr_gate_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         t8_run,
  input  wire logic         pin_cmd,
  input  wire logic         cmp1_cmd,
  input  wire logic         cmp2_cmd,
  output logic              external_gate_pin,
  output logic              comparator1_out,
  output logic              comparator2_out,
  output logic [BYTE_W-1:0] eight_bit_timer
);
  // pin and comparator levels follow what the bench commands
  assign external_gate_pin = pin_cmd;
  assign comparator1_out   = cmp1_cmd;
  assign comparator2_out   = cmp2_cmd;
  // timer counts up each cycle and wraps from top to zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eight_bit_timer <= T8_ZERO;
    end else if (t8_run) begin
      eight_bit_timer <= eight_bit_timer + 8'h01;
    end
  end
endmodule

// >>> dv/timer_gate_bench.sv
// self-checking bench for the gated timer
`timescale 1ns/1ps
module timer_gate_bench
  import tmr_gate_pkg::*;
();
  logic sys_clk, rst, count_tick, counter_on, gate_function_enable;
  logic [1:0] gate_source_select;
  logic gate_polarity, toggle_mode_enable, single_pulse_enable, pulse_arm_set;
  logic cmp1_sync_enable, cmp2_sync_enable, external_gate_pin, seen;
  logic [BYTE_W-1:0] eight_bit_timer, count_wdata;
  logic comparator1_out, comparator2_out, overflow_irq_enable;
  logic gate_event_irq_enable, peripheral_irq_enable, global_irq_enable;
  logic overflow_flag_clear, gate_event_flag_clear, sleep_mode, sync_disable;
  logic secondary_osc_select, count_low_we, count_high_we, capture_mode;
  logic capture_event, auto_conv_trigger, compare_event, pulse_arm_status;
  logic [CNT_W-1:0] count_value, capture_compare_pair, c;
  logic gate_level_status, overflow_flag, gate_event_flag, overflow_irq;
  logic gate_event_irq, wake_request, secondary_osc_run;
  logic pin_cmd, cmp1_cmd, cmp2_cmd, t8_run;
  int   err_total, n_tests, cyc;
  timer_gate timer_gate_i (
    .sys_clk(sys_clk), .rst(rst), .count_tick(count_tick),
    .counter_on(counter_on), .gate_function_enable(gate_function_enable),
    .gate_source_select(gate_source_select), .gate_polarity(gate_polarity),
    .toggle_mode_enable(toggle_mode_enable),
    .single_pulse_enable(single_pulse_enable), .pulse_arm_set(pulse_arm_set),
    .cmp1_sync_enable(cmp1_sync_enable), .cmp2_sync_enable(cmp2_sync_enable),
    .external_gate_pin(external_gate_pin), .eight_bit_timer(eight_bit_timer),
    .comparator1_out(comparator1_out), .comparator2_out(comparator2_out),
    .overflow_irq_enable(overflow_irq_enable),
    .gate_event_irq_enable(gate_event_irq_enable),
    .peripheral_irq_enable(peripheral_irq_enable),
    .global_irq_enable(global_irq_enable),
    .overflow_flag_clear(overflow_flag_clear),
    .gate_event_flag_clear(gate_event_flag_clear),
    .sleep_mode(sleep_mode), .sync_disable(sync_disable),
    .secondary_osc_select(secondary_osc_select),
    .count_low_we(count_low_we), .count_high_we(count_high_we),
    .count_wdata(count_wdata), .capture_mode(capture_mode),
    .capture_event(capture_event), .auto_conv_trigger(auto_conv_trigger),
    .count_value(count_value), .capture_compare_pair(capture_compare_pair),
    .compare_event(compare_event), .pulse_arm_status(pulse_arm_status),
    .gate_level_status(gate_level_status), .overflow_flag(overflow_flag),
    .gate_event_flag(gate_event_flag), .overflow_irq(overflow_irq),
    .gate_event_irq(gate_event_irq), .wake_request(wake_request),
    .secondary_osc_run(secondary_osc_run));
  gate_far_side gate_far_side_i (.sys_clk(sys_clk), .rst(rst),
    .t8_run(t8_run), .pin_cmd(pin_cmd), .cmp1_cmd(cmp1_cmd),
    .cmp2_cmd(cmp2_cmd), .external_gate_pin(external_gate_pin),
    .comparator1_out(comparator1_out), .comparator2_out(comparator2_out),
    .eight_bit_timer(eight_bit_timer));
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  // wait n edges, then step just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // compare one value and count the result
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle pulse on a strobe
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(1);
  endtask
  // byte write into the counter
  task automatic wr(input logic hi, input logic [7:0] d);
    count_wdata = d;
    {count_high_we, count_low_we} = {hi, !hi};
    step(1);
    {count_high_we, count_low_we} = 2'h0;
    step(1);
  endtask
  // pin high four cycles, low six
  task automatic pulse_pin;
    pin_cmd = 1'b1;
    step(4);
    pin_cmd = 1'b0;
    step(6);
  endtask
  // every source, both polarities except on the 8-bit timer overflow, with the gate function off
  task automatic t_sources;
    for (int s = 0; s < 4; s++) begin
      if (s != 1) begin
        gate_source_select = 2'(s);
        {pin_cmd, cmp1_cmd, cmp2_cmd} = {s == 0, s == 2, s == 3};
        gate_polarity = 1'b1;
        step(6);
        chk(gate_level_status, 1);
        pulse(gate_event_flag_clear);
        gate_polarity = 1'b0;
        step(6);
        chk(gate_level_status, 0);
        chk(gate_event_flag, 1);
        chk(gate_event_irq, 1);
      end
    end
    gate_source_select = SRC_T8_OVF;
    gate_polarity = 1'b1;
    step(6);
    seen = 1'b0;
    repeat (300) begin
      step(1);
      if (gate_level_status === 1'b1) seen = 1'b1;
    end
    chk(seen, 1);
    {pin_cmd, cmp1_cmd, cmp2_cmd} = 3'h0;
    gate_source_select = SRC_PIN;
  endtask
  // wrap, enables, sleep and stop
  task automatic t_overflow;
    counter_on = 1'b1;
    wr(1, 8'hff);
    wr(0, 8'hfe);
    step(4);
    chk(overflow_flag, 1);
    chk(count_value >> 4, 0);
    chk(overflow_irq, 0);
    global_irq_enable = 1'b1;
    step(1);
    chk(overflow_irq, 1);
    {sleep_mode, sync_disable} = 2'h3;
    c = count_value;
    step(4);
    chk(wake_request, 1);
    chk(count_value != c, 1);
    chk(secondary_osc_run, 1);
    sync_disable = 1'b0;
    step(1);
    c = count_value;
    step(4);
    chk(count_value, c);
    chk(secondary_osc_run, 1);
    {sleep_mode, counter_on} = 2'h0;
    step(1);
    c = count_value;
    step(4);
    chk(count_value, c);
    chk(overflow_irq, 0);
    counter_on = 1'b1;
    pulse(overflow_flag_clear);
    chk(overflow_flag, 0);
  endtask
  // auto trigger clears; a byte write beats it
  task automatic t_auto;
    wr(1, 8'h12);
    auto_conv_trigger = 1'b1;
    step(1);
    auto_conv_trigger = 1'b0;
    chk(count_value, 0);
    chk(overflow_flag, 0);
    step(1);
    count_wdata = 8'h5a;
    {count_low_we, auto_conv_trigger} = 2'h3;
    step(1);
    {count_low_we, auto_conv_trigger} = 2'h0;
    chk(count_value, 16'h005a);
  endtask
  // capture copy and compare match on a stopped counter
  task automatic t_capture;
    counter_on = 1'b0;
    wr(1, 8'h56);
    wr(0, 8'h78);
    capture_mode = 1'b1;
    pulse(capture_event);
    chk(capture_compare_pair, 16'h5678);
    capture_mode = 1'b0;
    step(1);
    chk(compare_event, 1);
    wr(0, 8'h79);
    chk(compare_event, 0);
    counter_on = 1'b1;
  endtask
  // toggle stage flips per rising edge; cleared by off or disable
  task automatic t_toggle;
    toggle_mode_enable = 1'b1;
    step(6);
    chk(gate_level_status, 0);
    pulse_pin;
    chk(gate_level_status, 1);
    pulse_pin;
    chk(gate_level_status, 0);
    pulse_pin;
    counter_on = 1'b0;
    step(6);
    chk(gate_level_status, 0);
    counter_on = 1'b1;
    pulse_pin;
    toggle_mode_enable = 1'b0;
    step(6);
    chk(gate_level_status, 0);
    toggle_mode_enable = 1'b1;
    step(6);
    chk(gate_level_status, 0);
    toggle_mode_enable = 1'b0;
  endtask
  // single pulse, alone and with toggle
  task automatic t_single;
    gate_function_enable = 1'b1;
    pulse(gate_event_flag_clear);
    single_pulse_enable = 1'b1;
    step(1);
    pulse(pulse_arm_set);
    chk(pulse_arm_status, 1);
    c = count_value;
    pin_cmd = 1'b1;
    step(10);
    chk(pulse_arm_status, 1);
    pin_cmd = 1'b0;
    step(8);
    chk(pulse_arm_status, 0);
    c = count_value - c;
    chk(c >= 8 && c <= 12, 1);
    chk(gate_event_flag, 1);
    c = count_value;
    pulse_pin;
    chk(count_value, c);
    toggle_mode_enable = 1'b1;
    step(1);
    pulse(pulse_arm_set);
    c = count_value;
    pulse_pin;
    step(20);
    pulse_pin;
    c = count_value - c;
    chk(c >= 28 && c <= 32, 1);
    chk(pulse_arm_status, 0);
    {single_pulse_enable, toggle_mode_enable} = 2'h0;
  endtask
  // counts and verdict, then end of run
  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end
  // main sequence
  initial begin
    {err_total, n_tests, cyc} = '0;
    {sys_clk, counter_on, gate_function_enable, gate_source_select,
     gate_polarity, toggle_mode_enable, single_pulse_enable, pulse_arm_set,
     cmp2_sync_enable, global_irq_enable, overflow_flag_clear,
     gate_event_flag_clear, sleep_mode, sync_disable, count_low_we,
     count_high_we, count_wdata, capture_mode, capture_event,
     auto_conv_trigger, pin_cmd, cmp1_cmd, cmp2_cmd} = '0;
    {rst, count_tick, cmp1_sync_enable, overflow_irq_enable, t8_run,
     peripheral_irq_enable, gate_event_irq_enable,
     secondary_osc_select} = 8'hff;
    step(3);
    rst = 1'b0;
    chk(count_value, CNT_RESET);
    t_sources;
    t_overflow;
    t_auto;
    t_capture;
    t_toggle;
    t_single;
    print_verdict;
  end
endmodule

// >>> include/tmr_gate_pkg.sv
// shared constants for the gated timer block
package tmr_gate_pkg;
  localparam int CNT_W = 16;                        // counter width
  localparam int BYTE_W = 8;                        // byte width
  localparam logic [1:0] SRC_PIN = 2'h0;            // gate pin source
  localparam logic [1:0] SRC_T8_OVF = 2'h1;         // 8-bit timer overflow
  localparam logic [1:0] SRC_CMP1 = 2'h2;           // comparator 1
  localparam logic [1:0] SRC_CMP2 = 2'h3;           // comparator 2
  localparam logic [15:0] CNT_RESET = 16'h0000;     // counter reset value
  localparam logic [15:0] CNT_MAX = 16'hffff;       // last count before wrap
  localparam logic [7:0] T8_MAX = 8'hff;            // 8-bit timer top
  localparam logic [7:0] T8_ZERO = 8'h00;           // 8-bit timer wrap value
endpackage
